// *** pqc_pkg.sv ***
// Packet queue, interrupt and power control: shared constants.
// Assumes a 16-bit register port with 4-bit word addresses.
package pqc_pkg;
	localparam logic [3:0] A_CMD = 4'h0;
	localparam logic [3:0] A_PNR = 4'h1;
	localparam logic [3:0] A_ACK = 4'h2;
	localparam logic [3:0] A_TXST = 4'h3;
	localparam logic [3:0] A_QPORT = 4'h4;
	localparam logic [3:0] A_TCR = 4'h5;
	localparam logic [3:0] A_IST = 4'h6;
	localparam logic [3:0] A_MASK = 4'h7;
	localparam logic [3:0] A_RESV = 4'h8;
	localparam logic [3:0] A_FREE = 4'h9;
	localparam logic [3:0] A_SIZE = 4'hA;
	localparam logic [3:0] A_CTRL = 4'hB;
	localparam logic [3:0] A_RXQ = 4'hC;
	localparam logic [7:0] CMD_ALLOC = 8'h20;
	localparam logic [7:0] CMD_RXREL = 8'h80;
	localparam logic [7:0] CMD_REL = 8'hA0;
	localparam logic [7:0] CMD_ENQ = 8'hC0;
	localparam logic [7:0] ACK_TX = 8'h02;
	localparam logic [15:0] QPORT_MASK = 16'h003F;
	localparam int TCR_EN = 0;
	localparam int TCR_AUTO = 1;
	localparam int IST_RX = 0;
	localparam int IST_TX = 1;
	localparam int IST_TXE = 2;
	localparam int CTRL_SRST = 7;
	localparam int CTRL_SLEEP = 13;
	localparam int ALLOC_FAIL = 7;
	localparam int QP_EMPTY = 7;
	localparam int PG_LSB = 8;
	localparam logic [1:0] TCR_RST = 2'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	typedef enum logic [1:0] {PQC_EXT, PQC_INT, PQC_SLEEP} pqc_mode_t;
endpackage

// *** pqc_top.sv ***
// Packet queue, interrupt and power control for a 10 Mb/s controller.
// Assumes single-cycle register strobes and media side pulses on clock.
//
// How it works
// RULE1 - Command 0x00A0 frees the packet named in packet_number_register.
// RULE2 - Command 0x00C0 queues packet_number_register for transmit.
// RULE3 - Byte 0x02 at the acknowledge location pops the completion queue.
// RULE4 - tx_status_word bit 0 is one after success, zero after failure.
// RULE5 - Queue port gives the completed packet number in its low six bits.
// RULE6 - Failure clears tx_enable_bit; software sets it again to resume.
// RULE7 - Only the writer requests memory: CPU for transmit, media for receive.
// RULE8 - Receive allocation fails while free memory is at or below reservation.
// RULE9 - Zero reservation means first-come first-served over all memory.
// RULE10 - A reception in progress completes; new ones wait for free memory.
// RULE11 - Free memory and memory size read back and ignore writes.
// RULE12 - Receive flag is up while the received queue is not empty.
// RULE13 - Transmit flag is up while the completion queue is not empty.
// RULE14 - Transmit-empty flag is up while the transmit queue is empty.
// RULE15 - With auto release, good packets skip completion and free memory.
// RULE16 - With auto release, failures still raise the flag and stop sending.
// RULE17 - Queue port shows the oldest completed packet number.
// RULE18 - Sleep stops oscillator, floats bus and network, idles memories.
// RULE19 - Interrupt output floats in sleep only when entered by sleep_bit.
// RULE20 - Raw reset or soft_reset_bit overrides the sleep_pin request.
// RULE21 - encoder_select_pin and sleep_pin pick external, internal or sleep.
// RULE22 - Any register write or hardware reset clears sleep_bit; a control register write with the sleep bit set sets it instead.
// RULE23 - Interrupt handlers save and restore pointer and packet number.
// RULE24 - Interrupt is the OR of each flag gated by its mask bit.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
module pqc_top #(
	parameter int NPKT = 64,
	parameter int MEM_PAGES = 24
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic tx_done,
	input wire logic tx_ok,
	output logic tx_go,
	output logic [5:0] tx_head,
	input wire logic rx_alloc_req,
	input wire logic rx_alloc_first,
	input wire logic [3:0] rx_alloc_pages,
	output logic rx_alloc_ok,
	output logic rx_alloc_fail,
	output logic [5:0] rx_alloc_num,
	input wire logic rx_done,
	input wire logic rx_good,
	input wire logic reset_raw,
	input wire logic sleep_pin,
	input wire logic encoder_select_pin,
	output logic irq,
	output logic irq_oe,
	output logic osc_run,
	output logic data_bus_oe,
	output logic wide_io_select_n_oe,
	output logic net_oe,
	output logic mem_if_active,
	output logic ext_encoder
);
	localparam int PW = $clog2(NPKT);
	localparam int CW = PW + 1;
	localparam int FW = 8;

	// Queue pointers wrap at a power of two, so the depth must be one
	if (NPKT < 2 || NPKT > 64 || (1 << PW) != NPKT || MEM_PAGES < 1 || MEM_PAGES > 255) begin
		$error("pqc_top: NPKT or MEM_PAGES out of range");
	end

	// Lowest unused packet number, with a found flag on top
	function automatic logic [PW:0] first_free(input logic [NPKT-1:0] u);
		logic [PW:0] r;
		r = '0;
		for (int i = NPKT - 1; i >= 0; i--) begin
			if (!u[i])
				r = {1'b1, PW'(i)};
		end
		return r;
	endfunction

	// Register bus decode
	wire wr_cmd = wr && addr == pqc_pkg::A_CMD;
	wire [7:0] cmd = wdata[7:0];
	wire cmd_rel = wr_cmd && cmd == pqc_pkg::CMD_REL;
	wire cmd_enq = wr_cmd && cmd == pqc_pkg::CMD_ENQ;
	wire cmd_alloc = wr_cmd && cmd == pqc_pkg::CMD_ALLOC;
	wire cmd_rxrel = wr_cmd && cmd == pqc_pkg::CMD_RXREL;
	wire ack_w = wr && addr == pqc_pkg::A_ACK && wdata[7:0] == pqc_pkg::ACK_TX;

	logic [PW-1:0] pnr_reg;
	logic [1:0] tcr_reg;
	logic [2:0] mask_reg;
	logic [FW-1:0] resv_reg;
	logic [FW-1:0] free_reg;
	logic sleep_bit_reg;
	logic soft_reset_bit_reg;
	logic tx_status_word_reg;
	logic [7:0] alloc_res_reg;
	logic alloc_pend_reg;
	logic [3:0] alloc_pg_reg;
	logic [PW-1:0] rx_cur_reg;
	logic [NPKT-1:0] used_reg;
	logic [3:0] pages_mem [NPKT];

	// Three packet queues
	logic [PW-1:0] txq [NPKT];
	logic [PW-1:0] cq [NPKT];
	logic [PW-1:0] rq [NPKT];
	logic [PW-1:0] txq_wp, txq_rp, cq_wp, cq_rp, rq_wp, rq_rp;
	logic [CW-1:0] txq_cnt, cq_cnt, rq_cnt;
	wire txq_ne = txq_cnt != '0;
	wire cq_ne = cq_cnt != '0;
	wire rq_ne = rq_cnt != '0;
	wire [PW-1:0] txq_head = txq[txq_rp];
	wire [PW-1:0] cq_head = cq[cq_rp];
	wire [PW-1:0] rq_head = rq[rq_rp];

	wire tx_fin = tx_done && txq_ne;
	wire auto_rel = tx_fin && tx_ok && tcr_reg[pqc_pkg::TCR_AUTO]; // see RULE15
	wire cq_push = tx_fin && !auto_rel; // see RULE16
	wire cq_pop = ack_w && cq_ne; // see RULE3
	wire rq_push = rx_done && rx_good;
	wire rq_pop = cmd_rxrel && rq_ne;

	// Memory accounting
	wire [PW:0] pick = first_free(used_reg);
	wire [FW-1:0] rx_pg = FW'(rx_alloc_pages);
	wire [FW-1:0] cpu_pg = FW'(alloc_pg_reg);
	// A new frame must find free memory above the reservation
	wire rx_room_first = free_reg > resv_reg && free_reg >= rx_pg; // see RULE8
	wire rx_room_cont = free_reg >= rx_pg; // see RULE10
	wire rx_new_ok = rx_alloc_req && rx_alloc_first && rx_room_first && pick[PW];
	wire rx_grant = rx_alloc_req && (rx_new_ok || !rx_alloc_first && rx_room_cont);
	// Receive side wins a shared cycle; the CPU request waits one
	wire cpu_try = alloc_pend_reg && !rx_alloc_req; // see RULE7
	wire cpu_grant = cpu_try && free_reg >= cpu_pg && pick[PW]; // see RULE9

	wire rel_a = cmd_rel && used_reg[pnr_reg]; // see RULE1
	wire rel_b = auto_rel && used_reg[txq_head];
	wire rx_bad = rx_done && !rx_good;
	wire rel_c = (rq_pop || rx_bad) && used_reg[rq_pop ? rq_head : rx_cur_reg];
	wire [PW-1:0] rel_c_num = rq_pop ? rq_head : rx_cur_reg;
	wire [FW-1:0] rel_pg = (rel_a ? FW'(pages_mem[pnr_reg]) : '0)
		+ (rel_b && !(rel_a && txq_head == pnr_reg) ? FW'(pages_mem[txq_head]) : '0)
		+ (rel_c && !(rel_a && rel_c_num == pnr_reg) ? FW'(pages_mem[rel_c_num]) : '0);
	wire [FW-1:0] take_pg = (rx_grant ? rx_pg : '0) + (cpu_grant ? cpu_pg : '0);
	wire [FW-1:0] free_next = free_reg + rel_pg - take_pg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			used_reg <= '0;
			free_reg <= FW'(MEM_PAGES);
		end else begin
			used_reg <= (used_reg
				& ~(rel_a ? NPKT'(1) << pnr_reg : '0)
				& ~(rel_b ? NPKT'(1) << txq_head : '0)
				& ~(rel_c ? NPKT'(1) << rel_c_num : '0))
				| (rx_new_ok || cpu_grant ? NPKT'(1) << pick[PW-1:0] : '0);
			free_reg <= free_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rx_alloc_req && rx_new_ok)
			pages_mem[pick[PW-1:0]] <= rx_alloc_pages;
		else if (rx_grant)
			pages_mem[rx_cur_reg] <= pages_mem[rx_cur_reg] + rx_alloc_pages;
		else if (cpu_grant)
			pages_mem[pick[PW-1:0]] <= alloc_pg_reg;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alloc_pend_reg <= 1'b0;
			alloc_pg_reg <= '0;
			alloc_res_reg <= 8'h80;
			rx_cur_reg <= '0;
			rx_alloc_ok <= 1'b0;
			rx_alloc_fail <= 1'b0;
			rx_alloc_num <= '0;
		end else begin
			if (cmd_alloc) begin
				alloc_pend_reg <= 1'b1;
				alloc_pg_reg <= wdata[pqc_pkg::PG_LSB+:4];
				alloc_res_reg[pqc_pkg::ALLOC_FAIL] <= 1'b1;
			end else if (cpu_try) begin
				alloc_pend_reg <= 1'b0;
				alloc_res_reg <= {!cpu_grant, 1'b0, 6'(pick[PW-1:0])};
			end
			if (rx_new_ok)
				rx_cur_reg <= pick[PW-1:0];
			rx_alloc_ok <= rx_grant;
			rx_alloc_fail <= rx_alloc_req && !rx_grant; // see RULE8
			rx_alloc_num <= rx_new_ok ? 6'(pick[PW-1:0]) : 6'(rx_cur_reg);
		end
	end

	// Queue storage and pointers
	always_ff @(posedge clock) begin
		if (cmd_enq)
			txq[txq_wp] <= pnr_reg; // see RULE2
		if (cq_push)
			cq[cq_wp] <= txq_head;
		if (rq_push)
			rq[rq_wp] <= rx_cur_reg;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txq_wp <= '0;
			txq_rp <= '0;
			txq_cnt <= '0;
			cq_wp <= '0;
			cq_rp <= '0;
			cq_cnt <= '0;
			rq_wp <= '0;
			rq_rp <= '0;
			rq_cnt <= '0;
		end else begin
			txq_wp <= txq_wp + PW'(cmd_enq);
			txq_rp <= txq_rp + PW'(tx_fin);
			txq_cnt <= txq_cnt + CW'(cmd_enq) - CW'(tx_fin);
			cq_wp <= cq_wp + PW'(cq_push);
			cq_rp <= cq_rp + PW'(cq_pop);
			cq_cnt <= cq_cnt + CW'(cq_push) - CW'(cq_pop);
			rq_wp <= rq_wp + PW'(rq_push);
			rq_rp <= rq_rp + PW'(rq_pop);
			rq_cnt <= rq_cnt + CW'(rq_push) - CW'(rq_pop);
		end
	end

	// Control registers
	wire ctrl_w = wr && addr == pqc_pkg::A_CTRL;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pnr_reg <= '0;
			tcr_reg <= pqc_pkg::TCR_RST;
			mask_reg <= pqc_pkg::MASK_RST;
			resv_reg <= '0;
			sleep_bit_reg <= 1'b0;
			soft_reset_bit_reg <= 1'b0;
			tx_status_word_reg <= 1'b0;
		end else begin
			if (wr && addr == pqc_pkg::A_PNR)
				pnr_reg <= wdata[PW-1:0];
			if (wr && addr == pqc_pkg::A_TCR)
				tcr_reg <= wdata[1:0];
			else if (tx_fin && !tx_ok)
				tcr_reg[pqc_pkg::TCR_EN] <= 1'b0; // see RULE6
			if (wr && addr == pqc_pkg::A_MASK)
				mask_reg <= wdata[2:0];
			if (wr && addr == pqc_pkg::A_RESV)
				resv_reg <= wdata[FW-1:0];
			// Writing the bit itself is the only write that leaves it set
			if (wr)
				sleep_bit_reg <= ctrl_w && wdata[pqc_pkg::CTRL_SLEEP]; // see RULE22
			if (ctrl_w)
				soft_reset_bit_reg <= wdata[pqc_pkg::CTRL_SRST];
			if (tx_fin)
				tx_status_word_reg <= tx_ok; // see RULE4
		end
	end

	// Interrupt flags
	wire [2:0] ist;
	assign ist[pqc_pkg::IST_RX] = rq_ne; // see RULE12
	assign ist[pqc_pkg::IST_TX] = cq_ne; // see RULE13
	assign ist[pqc_pkg::IST_TXE] = !txq_ne; // see RULE14

	// Read mux; free and size have no write path
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (addr)
			pqc_pkg::A_CMD: rd_mux = {8'h00, alloc_res_reg};
			pqc_pkg::A_PNR: rd_mux = 16'(pnr_reg);
			pqc_pkg::A_TXST: rd_mux = 16'(tx_status_word_reg);
			pqc_pkg::A_QPORT: rd_mux = ((16'(!cq_ne) << pqc_pkg::QP_EMPTY)
				| 16'(cq_ne ? cq_head : '0)) & 16'h00FF; // see RULE5, see RULE17
			pqc_pkg::A_TCR: rd_mux = 16'(tcr_reg);
			pqc_pkg::A_IST: rd_mux = 16'(ist);
			pqc_pkg::A_MASK: rd_mux = 16'(mask_reg);
			pqc_pkg::A_RESV: rd_mux = 16'(resv_reg);
			pqc_pkg::A_FREE: rd_mux = 16'(free_reg); // see RULE11
			pqc_pkg::A_SIZE: rd_mux = 16'(MEM_PAGES);
			pqc_pkg::A_CTRL: rd_mux = (16'(sleep_bit_reg) << pqc_pkg::CTRL_SLEEP)
				| (16'(soft_reset_bit_reg) << pqc_pkg::CTRL_SRST);
			pqc_pkg::A_RXQ: rd_mux = (16'(!rq_ne) << pqc_pkg::QP_EMPTY) | 16'(rq_ne ? rq_head : '0);
			default: rd_mux = '0;
		endcase
	end

	// Pin synchronisers: change accepted when stages two and three agree
	logic [2:0] slp_s, enc_s;
	logic slp_f, enc_f, raw_rst_s;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// Encoder select idles high so no false external mode after reset
			slp_s <= '0;
			enc_s <= '1;
			slp_f <= 1'b0;
			enc_f <= 1'b1;
			raw_rst_s <= 1'b0;
		end else begin
			slp_s <= {slp_s[1:0], sleep_pin};
			enc_s <= {enc_s[1:0], encoder_select_pin};
			if (slp_s[1] == slp_s[2])
				slp_f <= slp_s[2];
			if (enc_s[1] == enc_s[2])
				enc_f <= enc_s[2];
			// Undeglitched on purpose: the oscillator must run at reset
			raw_rst_s <= reset_raw;
		end
	end

	wire pin_req = slp_f && !raw_rst_s && !soft_reset_bit_reg; // see RULE20
	pqc_pkg::pqc_mode_t mode_next;
	assign mode_next = sleep_bit_reg ? pqc_pkg::PQC_SLEEP
		: !enc_f ? pqc_pkg::PQC_EXT
		: pin_req ? pqc_pkg::PQC_SLEEP : pqc_pkg::PQC_INT; // see RULE21
	wire asleep = mode_next == pqc_pkg::PQC_SLEEP;

	// Registered outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
			irq <= 1'b0;
			irq_oe <= 1'b1;
			osc_run <= 1'b1;
			data_bus_oe <= 1'b1;
			wide_io_select_n_oe <= 1'b1;
			net_oe <= 1'b1;
			mem_if_active <= 1'b1;
			ext_encoder <= 1'b0;
			tx_go <= 1'b0;
			tx_head <= '0;
		end else begin
			rdata <= rd ? rd_mux : '0;
			irq <= |(ist & mask_reg); // see RULE24
			irq_oe <= !sleep_bit_reg; // see RULE19
			osc_run <= !asleep; // see RULE18
			data_bus_oe <= !asleep;
			wide_io_select_n_oe <= !asleep;
			net_oe <= !asleep;
			mem_if_active <= !asleep;
			ext_encoder <= mode_next == pqc_pkg::PQC_EXT;
			// Sending halts on failure until software re-arms the enable
			tx_go <= tcr_reg[pqc_pkg::TCR_EN] && txq_ne && !asleep && !tx_fin; // see RULE16
			tx_head <= txq_ne ? 6'(txq_head) : '0;
		end
	end

	chk_irq_or: assert property (@(posedge clock) disable iff (!rst_n) // see RULE24
		##1 irq == |($past(ist) & $past(mask_reg))) else $error("irq not OR of flags");
	chk_fail_clears: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
		tx_fin && !tx_ok && !(wr && addr == pqc_pkg::A_TCR) |=> !tcr_reg[0]
		##1 !tx_go) else $error("enable kept after failure");
	chk_auto_skip: assert property (@(posedge clock) disable iff (!rst_n) // see RULE15
		auto_rel && !cq_pop |=> cq_cnt == $past(cq_cnt)) else $error("auto release queued");
	wire irq_flag_tx = ist[pqc_pkg::IST_TX];
	chk_fail_push: assert property (@(posedge clock) disable iff (!rst_n) // see RULE16
		tx_fin && !tx_ok && !cq_pop |=> cq_cnt == $past(cq_cnt) + 1'b1 ##1 irq_flag_tx)
		else $error("failure not queued");
	chk_resv_block: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
		rx_alloc_req && rx_alloc_first && free_reg <= resv_reg |=> rx_alloc_fail && !rx_alloc_ok)
		else $error("receive allocated inside reservation");
	chk_wr_wakes: assert property (@(posedge clock) disable iff (!rst_n) // see RULE22
		wr && !ctrl_w |=> !sleep_bit_reg ##1 irq_oe) else $error("write left sleep set");
	chk_raw_gate: assert property (@(posedge clock) disable iff (!rst_n) // see RULE20
		raw_rst_s && !sleep_bit_reg |=> osc_run) else $error("oscillator stopped in reset");
	chk_bit_floats: assert property (@(posedge clock) disable iff (!rst_n) // see RULE19
		sleep_bit_reg |=> !irq_oe && !osc_run && !data_bus_oe) else $error("bit sleep wrong");
	chk_qport_low: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
		rd && addr == pqc_pkg::A_QPORT && cq_ne |=> rdata[5:0] == 6'($past(cq_head))
		&& rdata[15:8] == 8'h00) else $error("queue port wrong");
	chk_rd_once: assert property (@(posedge clock) disable iff (!rst_n)
		!rd |=> rdata == '0) else $error("read data outside its cycle");

	cov_tx_fail: cover property (@(posedge clock) disable iff (!rst_n) tx_fin && !tx_ok);
	cov_auto: cover property (@(posedge clock) disable iff (!rst_n) auto_rel ##1 !txq_ne);
	cov_resv: cover property (@(posedge clock) disable iff (!rst_n) rx_alloc_fail);
	cov_pin_sleep: cover property (@(posedge clock) disable iff (!rst_n)
		pin_req && enc_f ##1 !osc_run && irq_oe);
endmodule

// *** pqc_media.sv ***
// Media side model: transmit completion and receive allocation pulses.
// Assumes the bench calls one task at a time; released lines show inverted data.
`timescale 1ns/1ns
module pqc_media (
	input wire logic clock,
	input wire logic tx_go,
	output logic tx_done,
	output logic tx_ok,
	output logic rx_alloc_req,
	output logic rx_alloc_first,
	output logic [3:0] rx_alloc_pages,
	input wire logic rx_alloc_ok,
	input wire logic rx_alloc_fail,
	output logic rx_done,
	output logic rx_good
);
	initial begin
		// Only the strobes idle low; qualifiers mean nothing until a strobe
		{tx_done, rx_alloc_req, rx_done} = 3'h0;
	end
	// Waits up to 40 cycles for tx_go, then sends even if the block offers no packet
	task automatic send(input logic ok);
		repeat (40) begin
			@(negedge clock);
			if (tx_go === 1'b1) break;
		end
		@(posedge clock);
		tx_done <= 1'b1;
		tx_ok <= ok;
		@(posedge clock);
		tx_done <= 1'b0;
		tx_ok <= ~ok;
	endtask
	// Receive side asks for its own pages
	task automatic alloc(input logic first, input logic [3:0] pages, output logic [1:0] res);
		@(posedge clock);
		rx_alloc_req <= 1'b1;
		rx_alloc_first <= first;
		rx_alloc_pages <= pages;
		@(posedge clock);
		rx_alloc_req <= 1'b0;
		rx_alloc_first <= ~first;
		rx_alloc_pages <= ~pages;
		@(negedge clock);
		res = {rx_alloc_fail, rx_alloc_ok};
	endtask
	// Frame end only after its last grant
	task automatic finish(input logic good);
		@(posedge clock);
		rx_done <= 1'b1;
		rx_good <= good;
		@(posedge clock);
		rx_done <= 1'b0;
		rx_good <= ~good;
	endtask
endmodule

// *** pqc_top_test.sv ***
// Bench for the packet queue, interrupt and power block.
// Assumes the media model beside it and the register map of the package.
`timescale 1ns/1ns
module pqc_top_test;
	typedef struct packed {logic w; logic [3:0] a; logic [15:0] d;} pqc_row_t;
	logic clock, rst_n, wr, rd, reset_raw, sleep_pin, encoder_select_pin;
	logic [3:0] addr, rx_alloc_pages;
	logic [15:0] wdata, rdata, r, pw, saved;
	logic tx_done, tx_ok, tx_go, rx_alloc_req, rx_alloc_first, rx_alloc_ok, rx_alloc_fail;
	logic rx_done, rx_good, irq, irq_oe, osc_run, data_bus_oe, wide_io_select_n_oe;
	logic net_oe, mem_if_active, ext_encoder;
	logic [5:0] tx_head, rx_alloc_num, pa, pb;
	logic [1:0] res;
	int fails, comparisons, cycles;
	pqc_row_t rows [0:13] = '{
		'{1'b0, pqc_pkg::A_TCR, 16'h0000},
		'{1'b0, pqc_pkg::A_MASK, 16'h0000},
		'{1'b0, pqc_pkg::A_FREE, 16'h0018},
		'{1'b0, pqc_pkg::A_SIZE, 16'h0018},
		'{1'b0, pqc_pkg::A_IST, 16'h0004},
		'{1'b0, pqc_pkg::A_QPORT, 16'h0080},
		'{1'b1, pqc_pkg::A_FREE, 16'h0005},
		'{1'b1, pqc_pkg::A_SIZE, 16'h0003},
		'{1'b0, pqc_pkg::A_FREE, 16'h0018},
		'{1'b0, pqc_pkg::A_SIZE, 16'h0018},
		'{1'b1, 4'hF, 16'h1234},
		'{1'b0, 4'hF, 16'h0000},
		'{1'b1, pqc_pkg::A_MASK, 16'h0007},
		'{1'b0, pqc_pkg::A_MASK, 16'h0007}
	};
	// Pin bits: ext_encoder 8, tx_go 7, irq 6, irq_oe 5, then the sleep-gated outputs
	assign pw = {7'h00, ext_encoder, tx_go, irq, irq_oe, osc_run, data_bus_oe,
		wide_io_select_n_oe, net_oe, mem_if_active};
	pqc_top #(.NPKT(64), .MEM_PAGES(24)) u_pqc_top (.clock, .rst_n, .addr, .wdata, .wr, .rd,
		.rdata, .tx_done, .tx_ok, .tx_go, .tx_head, .rx_alloc_req, .rx_alloc_first,
		.rx_alloc_pages, .rx_alloc_ok, .rx_alloc_fail, .rx_alloc_num, .rx_done, .rx_good,
		.reset_raw, .sleep_pin, .encoder_select_pin, .irq, .irq_oe, .osc_run, .data_bus_oe,
		.wide_io_select_n_oe, .net_oe, .mem_if_active, .ext_encoder);
	pqc_media u_pqc_media (.clock, .tx_go, .tx_done, .tx_ok, .rx_alloc_req, .rx_alloc_first,
		.rx_alloc_pages, .rx_alloc_ok, .rx_alloc_fail, .rx_done, .rx_good);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic stop_test;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Whole run needs about 280 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			stop_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		rd_reg(a, r);
		chk(r, exp);
	endtask
	task automatic queue_one(output logic [5:0] n);
		wr_reg(pqc_pkg::A_CMD, {8'h01, pqc_pkg::CMD_ALLOC});
		rd_reg(pqc_pkg::A_CMD, r);
		n = r[5:0];
		chk(r & 16'hFFC0, 16'h0000);
		wr_reg(pqc_pkg::A_PNR, {10'h000, n});
		wr_reg(pqc_pkg::A_CMD, {8'h00, pqc_pkg::CMD_ENQ});
	endtask
	task automatic rel(input logic [5:0] n);
		wr_reg(pqc_pkg::A_PNR, {10'h000, n});
		wr_reg(pqc_pkg::A_CMD, {8'h00, pqc_pkg::CMD_REL});
	endtask
	task automatic settle(input logic [15:0] exp);
		repeat (8) @(negedge clock);
		chk(pw & 16'hFFBF, exp);
		@(posedge clock);
	endtask
	initial begin
		{rst_n, wr, rd, reset_raw, sleep_pin} = 5'h00;
		encoder_select_pin = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		repeat (12) @(posedge clock);
		chk(pw, 16'h003F);
		rst_n <= 1'b1;
		repeat (6) @(negedge clock);
		for (int i = 0; i < 14; i++) begin
			if (rows[i].w) begin
				wr_reg(rows[i].a, rows[i].d);
			end else begin
				rchk(rows[i].a, rows[i].d);
			end
		end
		repeat (3) @(negedge clock);
		chk(pw, 16'h007F);
		queue_one(pa);
		queue_one(pb);
		rchk(pqc_pkg::A_FREE, 16'h0016);
		rchk(pqc_pkg::A_IST, 16'h0000);
		chk({10'h000, tx_head}, {10'h000, pa});
		chk(pw, 16'h003F);
		wr_reg(pqc_pkg::A_TCR, 16'h0001);
		repeat (2) @(negedge clock);
		chk(pw, 16'h00BF);
		u_pqc_media.send(1'b1);
		repeat (3) @(negedge clock);
		rchk(pqc_pkg::A_TXST, 16'h0001);
		rchk(pqc_pkg::A_IST, 16'h0002);
		rchk(pqc_pkg::A_QPORT, {10'h000, pa});
		u_pqc_media.send(1'b0);
		repeat (3) @(negedge clock);
		chk(pw, 16'h007F);
		rchk(pqc_pkg::A_TXST, 16'h0000);
		rchk(pqc_pkg::A_TCR, 16'h0000);
		rchk(pqc_pkg::A_IST, 16'h0006);
		rchk(pqc_pkg::A_QPORT, {10'h000, pa});
		rd_reg(pqc_pkg::A_PNR, saved);
		wr_reg(pqc_pkg::A_ACK, 16'h0002);
		rchk(pqc_pkg::A_QPORT, {10'h000, pb});
		rel(pb);
		rchk(pqc_pkg::A_FREE, 16'h0017);
		wr_reg(pqc_pkg::A_ACK, 16'h0002);
		rchk(pqc_pkg::A_QPORT, 16'h0080);
		rchk(pqc_pkg::A_IST, 16'h0004);
		wr_reg(pqc_pkg::A_PNR, saved);
		rchk(pqc_pkg::A_PNR, saved);
		rel(pa);
		wr_reg(pqc_pkg::A_MASK, 16'h0003);
		repeat (3) @(negedge clock);
		chk(pw, 16'h003F);
		wr_reg(pqc_pkg::A_TCR, 16'h0003);
		queue_one(pa);
		u_pqc_media.send(1'b1);
		repeat (3) @(negedge clock);
		rchk(pqc_pkg::A_FREE, 16'h0018);
		rchk(pqc_pkg::A_IST, 16'h0004);
		queue_one(pa);
		u_pqc_media.send(1'b0);
		repeat (3) @(negedge clock);
		rchk(pqc_pkg::A_IST, 16'h0006);
		rchk(pqc_pkg::A_TCR, 16'h0002);
		wr_reg(pqc_pkg::A_ACK, 16'h0002);
		rel(pa);
		u_pqc_media.alloc(1'b1, 4'h2, res);
		pa = rx_alloc_num;
		chk({14'h0000, res}, 16'h0001);
		rchk(pqc_pkg::A_FREE, 16'h0016);
		wr_reg(pqc_pkg::A_RESV, 16'h0016);
		u_pqc_media.alloc(1'b0, 4'h1, res);
		chk({14'h0000, res}, 16'h0001);
		u_pqc_media.finish(1'b1);
		repeat (2) @(negedge clock);
		rchk(pqc_pkg::A_IST, 16'h0005);
		rchk(pqc_pkg::A_RXQ, {10'h000, pa});
		u_pqc_media.alloc(1'b1, 4'h1, res);
		chk({14'h0000, res}, 16'h0002);
		wr_reg(pqc_pkg::A_CMD, {8'h00, pqc_pkg::CMD_RXREL});
		rchk(pqc_pkg::A_FREE, 16'h0018);
		rchk(pqc_pkg::A_IST, 16'h0004);
		rchk(pqc_pkg::A_RXQ, 16'h0080);
		u_pqc_media.alloc(1'b1, 4'h1, res);
		chk({14'h0000, res}, 16'h0001);
		u_pqc_media.finish(1'b0);
		rchk(pqc_pkg::A_FREE, 16'h0018);
		rchk(pqc_pkg::A_IST, 16'h0004);
		wr_reg(pqc_pkg::A_CTRL, 16'h2000);
		settle(16'h0000);
		wr_reg(4'hF, 16'h0000);
		settle(16'h003F);
		sleep_pin <= 1'b1;
		settle(16'h0020);
		reset_raw <= 1'b1;
		settle(16'h003F);
		reset_raw <= 1'b0;
		wr_reg(pqc_pkg::A_CTRL, 16'h0080);
		settle(16'h003F);
		wr_reg(pqc_pkg::A_CTRL, 16'h0000);
		settle(16'h0020);
		sleep_pin <= 1'b0;
		settle(16'h003F);
		encoder_select_pin <= 1'b0;
		settle(16'h013F);
		sleep_pin <= 1'b1;
		settle(16'h013F);
		stop_test();
	end
endmodule
